//--- core/bcc_err_pkg.sv
package bcc_err_pkg;
  // register indices on the local configuration port
  localparam logic [7:0] equalizer_error_threshold_off = 8'h43;
  localparam logic [7:0] control_channel_error_ctrl_off = 8'h46;
  localparam logic [7:0] port_select_off = 8'h4c;
  // reset values
  localparam logic [7:0] threshold_reset = 8'h01;
  localparam logic [7:0] error_ctrl_reset = 8'h20;
  localparam logic [7:0] port_select_reset = 8'h00;
  localparam logic [2:0] adapt_error_type_reset = 3'h7;
  // field positions in the error control register
  localparam int remote_read_ack_bit = 7;
  localparam int returned_data_bit = 6;
  localparam int enhanced_check_bit = 5;
  localparam int inject_hi = 4;
  localparam int inject_lo = 3;
  localparam int byte_sel_hi = 2;
  localparam int byte_sel_lo = 0;
  // number of receive ports and forward bytes eligible for injection
  localparam int num_ports = 4;
  localparam logic [3:0] first_bytes = 4'h8;
  // half relock period in clock cycles, default for error window
  localparam int relock_half_cycles = 1000;

  typedef enum logic [1:0] {
    inject_none,
    inject_crc_sel,
    inject_crc_next,
    inject_data_sel
  } inject_kind_e;

  // register write/read request from the local configuration port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // per-port forward channel byte/frame event stream
  typedef struct packed {
    logic byte_sent;
    logic frame_end;
  } fwd_evt_s;

  // link error events counted during adaptation
  typedef struct packed {
    logic clk_err;
    logic seq_err;
    logic parity_err;
  } link_err_s;
endpackage

//--- core/bcc_err_ctrl.sv
// What this block does
// RULE1 - per-port 8-bit equalizer threshold, resets to one
// RULE2 - host never writes zero threshold
// RULE3 - port select chooses which copy is accessed
// RULE4 - bit7 gives local ack at remote read
// RULE5 - host leaves bit7 clear for old partners
// RULE6 - bit6 checks data returned during ack
// RULE7 - detected returned-data error turns ack into nack
// RULE8 - host keeps bit6 clear for old partners
// RULE9 - bit5 default on, enhanced checks abort transaction
// RULE10 - two-bit field picks crc, next-crc or data error
// RULE11 - one programming gives exactly one error
// RULE12 - three-bit field picks among first eight bytes
// RULE13 - count errors half relock period, compare threshold
// RULE14 - type select picks clock, sequence, parity errors
// RULE15 - each port's settings independent of others
module bcc_err_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire bcc_err_pkg::reg_req_s i_req,
  input wire logic [2:0] i_adapt_error_type_select,
  input wire logic [3:0] i_remote_read_start,
  input wire logic [3:0] i_remote_ack,
  input wire logic [3:0] i_returned_data_bad,
  input wire logic [3:0] i_enh_error_seen,
  input wire bcc_err_pkg::fwd_evt_s [3:0] i_fwd_evt,
  input wire bcc_err_pkg::link_err_s [3:0] i_link_err,
  input wire logic [3:0] i_adapt_active,
  output logic [7:0] o_rdata,
  output logic [3:0] o_local_ack,
  output logic [3:0] o_local_nack,
  output logic [3:0] o_abort_transaction,
  output logic [3:0] o_force_crc_err,
  output logic [3:0] o_force_data_err,
  output logic [3:0] o_raise_equalizer
);
  // number of receive ports, each with its own copy of the settings
  localparam int np = bcc_err_pkg::num_ports;

  // how the block is organised:
  // - one shared port select decides which port copy the host reaches
  // - every port owns threshold, control, injection and window state
  // - all event outputs are registered one-cycle pulses
  // - read data is registered and holds until the next read
  //
  // the host side is a simple request struct; one request per cycle
  // is taken and back to back requests are allowed
  //
  // the far side delivers per-port pulses: read start, remote ack,
  // enhanced-check errors, forward byte and frame events, link errors
  //
  // limitation: the threshold is not guarded against zero; the host
  // is trusted to keep it at one or above
  //
  // limitation: only the first eight forward bytes of a frame can
  // carry an injected error; later bytes saturate the byte counter
  //
  // trade-off: the adaptation window length is a package constant
  // rather than a register, so the relock timer is not modelled

  // shared port select and read data
  logic [7:0] port_sel_q, port_sel_d;
  logic [7:0] rdata_q, rdata_d;
  // per-port state arrays
  logic [7:0] thold_q [np];
  logic [7:0] thold_d [np];
  logic [7:0] ectl_q [np];
  logic [7:0] ectl_d [np];
  logic inj_armed_q [np];          // one pending injection per write
  logic inj_armed_d [np];
  logic [3:0] byte_cnt_q [np];     // forward bytes since frame start
  logic [3:0] byte_cnt_d [np];
  logic inj_next_q [np];           // crc at the next frame end
  logic inj_next_d [np];
  logic [15:0] win_q [np];         // half relock window counter
  logic [15:0] win_d [np];
  logic [8:0] errs_q [np];         // saturating error count
  logic [8:0] errs_d [np];
  logic [3:0] ack_q, ack_d, nack_q, nack_d, abort_q, abort_d;
  logic [3:0] crc_q, crc_d, dat_q, dat_d, raise_q, raise_d;

  // port index taken from the low bits of the shared port select;
  // upper select bits are stored and read back but never decoded
  logic [1:0] sel_idx;
  assign sel_idx = port_sel_q[1:0];

  // next state of configuration, injection and adaptation counters
  //
  // per port the order inside the loop matters:
  // - register writes come first
  // - acknowledge, nack and abort pulses follow the stored control
  // - injection compares the byte count against the stored select
  // - adaptation counts errors over one window, then compares
  //
  // hazard: a control write landing in the same cycle as a matching
  // forward byte must not be swallowed by that byte; the fresh
  // programming wins and arms a new injection for a later byte
  //
  // hazard: the stored control (not the incoming write) decides the
  // response pulses, so a write takes effect one cycle later
  always_comb begin
    logic hit;
    logic wr_ctl;
    logic [1:0] kind;
    logic [2:0] cnt_inc;
    hit = 1'b0;
    wr_ctl = 1'b0;
    kind = 2'h0;
    cnt_inc = 3'h0;
    port_sel_d = port_sel_q;
    rdata_d = rdata_q;
    ack_d = '0;
    nack_d = '0;
    abort_d = '0;
    crc_d = '0;
    dat_d = '0;
    raise_d = '0;
    if (i_req.wr && i_req.addr == bcc_err_pkg::port_select_off) begin
      port_sel_d = i_req.wdata;
    end
    // read decode for the selected port copy
    if (i_req.rd) begin
      // RULE3 selected copy read
      if (i_req.addr == bcc_err_pkg::equalizer_error_threshold_off) begin
        rdata_d = thold_q[sel_idx];
      end else if (i_req.addr ==
                   bcc_err_pkg::control_channel_error_ctrl_off) begin
        rdata_d = ectl_q[sel_idx];
      end else if (i_req.addr == bcc_err_pkg::port_select_off) begin
        rdata_d = port_sel_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
    for (int p = 0; p < np; p++) begin
      thold_d[p] = thold_q[p];
      ectl_d[p] = ectl_q[p];
      inj_armed_d[p] = inj_armed_q[p];
      byte_cnt_d[p] = byte_cnt_q[p];
      inj_next_d[p] = inj_next_q[p];
      win_d[p] = win_q[p];
      errs_d[p] = errs_q[p];
      // RULE15 only selected port written
      hit = i_req.wr && (sel_idx == p[1:0]);
      // control write to this port copy; it wins over a byte match
      wr_ctl = hit &&
               i_req.addr == bcc_err_pkg::control_channel_error_ctrl_off;
      // RULE1 threshold storage
      if (hit && i_req.addr == bcc_err_pkg::equalizer_error_threshold_off)
      begin
        thold_d[p] = i_req.wdata;
      end
      if (hit && i_req.addr == bcc_err_pkg::control_channel_error_ctrl_off)
      begin
        ectl_d[p] = i_req.wdata;
        // RULE11 arm single injection
        inj_armed_d[p] = (i_req.wdata[bcc_err_pkg::inject_hi:
                                       bcc_err_pkg::inject_lo] != 2'h0);
      end
      // RULE4 local ack at remote read start
      ack_d[p] = i_remote_read_start[p] &&
                 ectl_q[p][bcc_err_pkg::remote_read_ack_bit];
      // RULE6 returned data check
      if (i_remote_ack[p]) begin
        // RULE7 ack becomes nack on error
        if (ectl_q[p][bcc_err_pkg::returned_data_bit] &&
            i_returned_data_bad[p]) begin
          nack_d[p] = 1'b1;
        end else begin
          ack_d[p] = 1'b1;
        end
      end
      // RULE9 enhanced errors abort transaction
      abort_d[p] = i_enh_error_seen[p] &&
                   ectl_q[p][bcc_err_pkg::enhanced_check_bit];
      // forward byte counting; frame end restarts the count
      kind = ectl_q[p][bcc_err_pkg::inject_hi:bcc_err_pkg::inject_lo];
      if (i_fwd_evt[p].frame_end) begin
        byte_cnt_d[p] = 4'h0;
        if (inj_next_q[p]) begin
          inj_next_d[p] = 1'b0;
          crc_d[p] = 1'b1;
        end
      end else if (i_fwd_evt[p].byte_sent) begin
        if (byte_cnt_q[p] != bcc_err_pkg::first_bytes) begin
          byte_cnt_d[p] = byte_cnt_q[p] + 4'h1;
        end
        // RULE12 match selected byte
        // a new programming in this cycle keeps its own arming
        if (inj_armed_q[p] && !wr_ctl && byte_cnt_q[p] == {1'b0, ectl_q[p][
            bcc_err_pkg::byte_sel_hi:bcc_err_pkg::byte_sel_lo]}) begin
          inj_armed_d[p] = 1'b0;
          // RULE10 error kind decode
          case (bcc_err_pkg::inject_kind_e'(kind))
            bcc_err_pkg::inject_crc_sel: crc_d[p] = 1'b1;
            bcc_err_pkg::inject_crc_next: inj_next_d[p] = 1'b1;
            bcc_err_pkg::inject_data_sel: dat_d[p] = 1'b1;
            default: inj_armed_d[p] = 1'b0;
          endcase
        end
      end
      // RULE13 half relock window counting
      if (!i_adapt_active[p]) begin
        win_d[p] = 16'h0;
        errs_d[p] = 9'h0;
      end else if (win_q[p] == 16'(bcc_err_pkg::relock_half_cycles - 1))
      begin
        win_d[p] = 16'h0;
        errs_d[p] = 9'h0;
        raise_d[p] = (errs_q[p] > {1'b0, thold_q[p]});
      end else begin
        win_d[p] = win_q[p] + 16'h1;
        // RULE14 error type selection
        cnt_inc = {2'h0, i_link_err[p].clk_err &
                         i_adapt_error_type_select[2]}
                + {2'h0, i_link_err[p].seq_err &
                         i_adapt_error_type_select[1]}
                + {2'h0, i_link_err[p].parity_err &
                         i_adapt_error_type_select[0]};
        if (errs_q[p] < 9'h1f0) begin
          errs_d[p] = errs_q[p] + {6'h0, cnt_inc};
        end
      end
    end
  end

  // registers only
  //
  // every register runs on every edge; the reset branch loads
  // constants only, so reset release stays clean
  //
  // after reset every port holds threshold one and the enhanced
  // check enabled, with no injection armed and no window running
  //
  // trade-off: outputs are registered, costing one cycle of latency
  // but giving glitch-free pulses to the link logic
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      port_sel_q <= bcc_err_pkg::port_select_reset;
      rdata_q <= 8'h00;
      ack_q <= 4'h0;
      nack_q <= 4'h0;
      abort_q <= 4'h0;
      crc_q <= 4'h0;
      dat_q <= 4'h0;
      raise_q <= 4'h0;
      for (int p = 0; p < np; p++) begin
        thold_q[p] <= bcc_err_pkg::threshold_reset;
        ectl_q[p] <= bcc_err_pkg::error_ctrl_reset;
        inj_armed_q[p] <= 1'b0;
        byte_cnt_q[p] <= 4'h0;
        inj_next_q[p] <= 1'b0;
        win_q[p] <= 16'h0;
        errs_q[p] <= 9'h0;
      end
    end else begin
      port_sel_q <= port_sel_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      nack_q <= nack_d;
      abort_q <= abort_d;
      crc_q <= crc_d;
      dat_q <= dat_d;
      raise_q <= raise_d;
      for (int p = 0; p < np; p++) begin
        thold_q[p] <= thold_d[p];
        ectl_q[p] <= ectl_d[p];
        inj_armed_q[p] <= inj_armed_d[p];
        byte_cnt_q[p] <= byte_cnt_d[p];
        inj_next_q[p] <= inj_next_d[p];
        win_q[p] <= win_d[p];
        errs_q[p] <= errs_d[p];
      end
    end
  end

  // outputs straight from flip-flops
  // read data holds until the next read request
  // each event output is a single-cycle pulse per port
  assign o_rdata = rdata_q;
  assign o_local_ack = ack_q;
  assign o_local_nack = nack_q;
  assign o_abort_transaction = abort_q;
  assign o_force_crc_err = crc_q;
  assign o_force_data_err = dat_q;
  assign o_raise_equalizer = raise_q;
endmodule

//--- dv/bcc_err_ctrl_properties.sv
module bcc_err_ctrl_properties (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire bcc_err_pkg::reg_req_s i_req,
  input wire logic [3:0] i_remote_read_start,
  input wire logic [3:0] i_remote_ack,
  input wire logic [3:0] i_returned_data_bad,
  input wire logic [3:0] i_enh_error_seen,
  input wire bcc_err_pkg::fwd_evt_s [3:0] i_fwd_evt,
  input wire logic [3:0] i_adapt_active,
  input wire logic [7:0] o_rdata,
  input wire logic [3:0] o_local_ack,
  input wire logic [3:0] o_local_nack,
  input wire logic [3:0] o_abort_transaction,
  input wire logic [3:0] o_force_crc_err,
  input wire logic [3:0] o_force_data_err,
  input wire logic [3:0] o_raise_equalizer
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  logic [3:0] sent; // byte events gathered per port
  always_comb for (int i = 0; i < 4; i++) sent[i] = i_fwd_evt[i].byte_sent;
  property p_nack; (o_local_nack & ~$past(i_remote_ack & i_returned_data_bad))
    == 4'h0; endproperty
  a_nack: assert property (p_nack) else $error("nack without bad ack");
  // every remote ack answered next cycle as ack or nack
  property p_resp; ($past(i_remote_ack) & ~(o_local_ack | o_local_nack))
    == 4'h0; endproperty
  a_resp: assert property (p_resp) else $error("remote ack lost");
  property p_ack; (o_local_ack & ~$past(i_remote_ack | i_remote_read_start))
    == 4'h0; endproperty
  a_ack: assert property (p_ack) else $error("ack without cause");
  property p_abort; (o_abort_transaction & ~$past(i_enh_error_seen))
    == 4'h0; endproperty
  a_abort: assert property (p_abort) else $error("abort without cause");
  property p_data; (o_force_data_err & ~$past(sent)) == 4'h0; endproperty
  a_data: assert property (p_data) else $error("data error off byte");
  // a forced error never lasts two cycles
  property p_once; ((o_force_crc_err | o_force_data_err)
    & $past(o_force_crc_err | o_force_data_err)) == 4'h0; endproperty
  a_once: assert property (p_once) else $error("forced error repeated");
  property p_hold; !$past(i_req.rd) |-> $stable(o_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_raise; (o_raise_equalizer & ~$past(i_adapt_active))
    == 4'h0; endproperty
  a_raise: assert property (p_raise) else $error("raise while idle");
endmodule
bind bcc_err_ctrl bcc_err_ctrl_properties chk (.i_sys_clk, .i_reset_n,
  .i_req, .i_remote_read_start, .i_remote_ack, .i_returned_data_bad,
  .i_enh_error_seen, .i_fwd_evt, .i_adapt_active, .o_rdata, .o_local_ack,
  .o_local_nack, .o_abort_transaction, .o_force_crc_err, .o_force_data_err,
  .o_raise_equalizer);

//--- dv/link_partner_model.sv
module link_partner_model (
  input wire logic i_sys_clk,
  output logic [3:0] o_read_start,
  output logic [3:0] o_ack,
  output logic [3:0] o_bad,
  output logic [3:0] o_enh_err,
  output bcc_err_pkg::fwd_evt_s [3:0] o_fwd,
  output bcc_err_pkg::link_err_s [3:0] o_link_err
);
  timeunit 1ns;
  timeprecision 1ns;
  int last = -1; // index of last forward event, 10 is frame end
  initial {o_read_start, o_ack, o_bad, o_enh_err, o_fwd, o_link_err} = '0;
  // two frames of ten bytes; idle gap lets each pulse be told apart
  task automatic frames(input int p);
    repeat (2) for (int i = 0; i <= 10; i++) begin
      @(negedge i_sys_clk);
      last = i;
      o_fwd[p] = (i == 10) ? 2'h1 : 2'h2;
      @(negedge i_sys_clk);
      o_fwd[p] = '0;
    end
  endtask
  // one-cycle event; bad data only when the bench asks for it
  task automatic ev(input int k, input int p, input logic bad);
    @(negedge i_sys_clk);
    o_bad[p] = bad;
    case (k)
      0: o_read_start[p] = 1'h1;
      1: o_ack[p] = 1'h1;
      2: o_enh_err[p] = 1'h1;
      default: o_link_err[p] = 3'h7;
    endcase
    @(negedge i_sys_clk);
    {o_read_start, o_ack, o_enh_err, o_link_err} = '0;
  endtask
endmodule

//--- dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 0;
  logic i_reset_n = 0;
  bcc_err_pkg::reg_req_s req = '0;
  logic [2:0] sel_type = 3'h7;
  logic [3:0] active = 4'h0;
  logic [3:0] rs, ra, bad, enh, lack, lnack, abt, crc, dat, rse;
  bcc_err_pkg::fwd_evt_s [3:0] fwd;
  bcc_err_pkg::link_err_s [3:0] lerr;
  logic [7:0] rdata;
  logic [5:0][3:0] outs;
  logic [7:0] thr[4], ctl[4]; // register model per port
  int fails = 0, checked = 0, seed = 32'h7892be6a, p, s, at;
  int n[6][4]; // pulse counts per output and port
  assign outs = {lack, lnack, abt, crc, dat, rse};
  initial forever #25 i_sys_clk = ~i_sys_clk;
  bcc_err_ctrl bcc_err_ctrl_inst (.i_sys_clk, .i_reset_n, .i_req(req),
    .i_adapt_error_type_select(sel_type), .i_remote_read_start(rs),
    .i_remote_ack(ra), .i_returned_data_bad(bad), .i_enh_error_seen(enh),
    .i_fwd_evt(fwd), .i_link_err(lerr), .i_adapt_active(active),
    .o_rdata(rdata), .o_local_ack(lack), .o_local_nack(lnack),
    .o_abort_transaction(abt), .o_force_crc_err(crc),
    .o_force_data_err(dat), .o_raise_equalizer(rse));
  link_partner_model link_partner_model_inst (.i_sys_clk, .o_read_start(rs),
    .o_ack(ra), .o_bad(bad), .o_enh_err(enh), .o_fwd(fwd), .o_link_err(lerr));
  // count pulses; note the forward event behind a forced error
  always @(negedge i_sys_clk) begin
    for (int i = 0; i < 24; i++) n[i / 4][i % 4] += outs[i / 4][i % 4];
    if ((crc | dat) != 4'h0) at = link_partner_model_inst.last;
  end
  task automatic chk(input string t, input logic [7:0] e, g);
    checked++;
    if (e !== g) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", t, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(negedge i_sys_clk);
    req = {w, ~w, a, d};
    @(negedge i_sys_clk);
    req = '0;
  endtask
  task automatic rd(input string t, input logic [7:0] a, e);
    acc(0, a, 8'h0);
    @(negedge i_sys_clk);
    chk(t, e, rdata);
  endtask
  task automatic wp(input int q, input logic [7:0] a, d);
    acc(1, 8'h4c, 8'(q));
    acc(1, a, d);
  endtask
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    results();
  end
  initial begin
    repeat (4) @(negedge i_sys_clk);
    i_reset_n = 1;
    for (int i = 0; i < 4; i++) begin
      acc(1, 8'h4c, 8'(i));
      rd("thr", 8'h43, 8'h01);
      rd("ctl", 8'h46, 8'h20);
      // never zero, the host keeps that promise
      thr[i] = 8'($random(seed)) | 8'h01;
      ctl[i] = 8'($random(seed));
      acc(1, 8'h43, thr[i]);
      acc(1, 8'h46, ctl[i]);
    end
    for (int i = 0; i < 4; i++) begin
      acc(1, 8'h4c, 8'(i));
      rd("thr", 8'h43, thr[i]);
      rd("ctl", 8'h46, ctl[i]);
    end
    rd("unmapped", 8'h50, 8'h00);
    $display("test registers done");
    // partner supports enhanced checks, bits 7/6 allowed
    // k: bit0 local ack and enhanced, bit1 data check, bit2 bad data
    for (int k = 0; k < 8; k++) begin
      p = k % 4;
      wp(p, 8'h46, {k[0], k[1], k[0], 5'h0});
      n = '{default: 0};
      link_partner_model_inst.ev(0, p, k[2]);
      link_partner_model_inst.ev(1, p, k[2]);
      link_partner_model_inst.ev(2, p, k[2]);
      repeat (2) @(negedge i_sys_clk);
      chk("ack", k[0] + !(k[1] & k[2]), 8'(n[5][p]));
      chk("nack", k[1] & k[2], 8'(n[4][p]));
      chk("abort", k[0], 8'(n[3][p]));
    end
    $display("test responses done");
    for (int m = 1; m < 4; m++) begin
      p = $unsigned($random(seed)) % 4;
      s = $unsigned($random(seed)) % 8;
      wp(p, 8'h46, {3'h1, m[1:0], s[2:0]});
      n = '{default: 0};
      link_partner_model_inst.frames(p);
      chk("crc", m != 3, 8'(n[2][p]));
      chk("data", m == 3, 8'(n[1][p]));
      chk("byte", (m == 2) ? 8'ha : 8'(s), 8'(at));
    end
    $display("test injection done");
    // c0 low limit, c1 high limit, c2 no error types counted
    for (int c = 0; c < 3; c++) begin
      active = 4'h0;
      sel_type = (c == 2) ? 3'h0 : 3'h7;
      wp(1, 8'h43, (c == 1) ? 8'hff : 8'h01);
      n = '{default: 0};
      active = 4'h2;
      repeat (22) begin
        link_partner_model_inst.ev(3, 1, 1'h0);
        repeat (48) @(negedge i_sys_clk);
      end
      chk("raise", c == 0, n[0][1] > 0);
    end
    $display("test adaptation done");
    results();
  end
endmodule
